// *** mpsc_pkg.sv ***
// package for the module power-state control block
// Function
// RQ1: wake request high wakes controller immediately
// RQ2: wake request low permits controller sleep
// RQ3: host never leaves wake request floating
// RQ4: broken tamper loop raises tamper indication
// RQ5: tamper monitoring runs in active and hibernate
// RQ6: unused tamper input tied to ground
// RQ7: power-down input overrides every other function
// RQ8: power-down low turns regulators off
// RQ9: power-down high turns regulators on
// RQ10: host holds power-down low 100 ms; the bench holds it low five cycles
// RQ11: indicator high active, low light, else tristate
// RQ12: host drives no IO in deepest hibernates
// RQ13: no serial traffic in any hibernate
// RQ14: async inputs pass two synchroniser stages
package mpsc_pkg;
  // power states, one-hot
  typedef enum logic [4:0] {
    PS_OFF = 5'h01,
    PS_ACTIVE = 5'h02,
    PS_LIGHT = 5'h04,
    PS_DEEP = 5'h08,
    PS_DEEPEST = 5'h10
  } mpsc_state_t;

  // hibernate depth requested by the internal controller
  typedef enum logic [1:0] {
    HIB_LIGHT = 2'h0,
    HIB_DEEP = 2'h1,
    HIB_DEEPEST = 2'h2
  } mpsc_hib_t;

  // sleep request from the internal controller
  typedef struct packed {
    logic req;
    mpsc_hib_t depth;
  } mpsc_sleep_t;

  // pin side of the indicator output
  typedef struct packed {
    logic out;
    logic oe;
  } mpsc_pin_t;

  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [7:0] TAMPER_DEBOUNCE = 8'h04;
  localparam logic RST_VAL = 1'b0;
endpackage

// *** mpsc_sync.sv ***
// two-flop level synchroniser
`timescale 1ns/1ps
module mpsc_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic asyncIn,
  output logic syncOut
);
  import mpsc_pkg::*;
  logic meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      syncOut <= RST_VAL;
    end
    else if (clkEn)
    begin
      meta_q <= asyncIn; // RQ14
      syncOut <= meta_q;
    end
  end
endmodule

// *** mpsc_power_ctrl.sv ***
// power-state, tamper and indicator control of the radio module
`timescale 1ns/1ps
module mpsc_power_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic wake_request_in,
  input wire logic powerDown_n,
  input wire logic tamper_loop_in,
  input wire mpsc_pkg::mpsc_sleep_t sleepReq,
  input wire logic tamperClear,
  output logic tamper_loop_out,
  output logic tamperFlag,
  output logic regulatorEn,
  output logic coreRun,
  output logic uartEnable,
  output logic ioSupplyEn,
  output logic indicatorOut,
  output logic indicatorOe,
  output mpsc_pkg::mpsc_state_t powerState
);
  import mpsc_pkg::*;

  logic wakeSync;
  logic pdSync;
  logic tamperSync;
  logic pdSync_q;
  mpsc_state_t state_q;
  mpsc_state_t state_d;
  logic [7:0] tamperCnt_q;
  mpsc_pin_t ind_d;

  // synchronise every pin input before use
  mpsc_sync uWake (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn(wake_request_in),
    .syncOut(wakeSync)
  );
  mpsc_sync uPd (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn(powerDown_n),
    .syncOut(pdSync)
  );
  mpsc_sync uTamper (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn(tamper_loop_in),
    .syncOut(tamperSync)
  );

  // next power state; power-down beats every other request
  always_comb
  begin
    state_d = state_q;
    if (!pdSync)
    begin
      state_d = PS_OFF; // RQ7 RQ8
    end
    else
    begin
      unique case (state_q)
        PS_OFF: state_d = PS_ACTIVE; // RQ9
        PS_ACTIVE:
        begin
          // sleep only honoured while wake is held low
          if (sleepReq.req && !wakeSync)
          begin
            unique case (sleepReq.depth) // RQ2
              HIB_DEEP: state_d = PS_DEEP;
              HIB_DEEPEST: state_d = PS_DEEPEST;
              default: state_d = PS_LIGHT;
            endcase
          end
        end
        PS_LIGHT, PS_DEEP, PS_DEEPEST:
        begin
          if (wakeSync)
          begin
            state_d = PS_ACTIVE; // RQ1
          end
        end
        default: state_d = PS_OFF;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= PS_OFF;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
    end
  end

  // last synced power-down level; resets low like the sync, so no false edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pdSync_q <= 1'b0;
    end
    else if (clkEn)
    begin
      pdSync_q <= pdSync;
    end
  end

  // state-derived outputs, all registered
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      powerState <= PS_OFF;
      regulatorEn <= 1'b0;
      coreRun <= 1'b0;
      uartEnable <= 1'b0;
      ioSupplyEn <= 1'b0;
    end
    else if (clkEn)
    begin
      powerState <= state_d;
      regulatorEn <= (state_d != PS_OFF); // RQ8 RQ9
      coreRun <= (state_d == PS_ACTIVE); // RQ1
      uartEnable <= (state_d == PS_ACTIVE); // RQ13
      // io rail dropped in the two deepest states
      ioSupplyEn <= (state_d == PS_ACTIVE) || (state_d == PS_LIGHT);
    end
  end

  // indicator pin drive per state
  always_comb
  begin
    ind_d = '{out: 1'b0, oe: 1'b0};
    unique case (state_d)
      PS_ACTIVE: ind_d = '{out: 1'b1, oe: 1'b1}; // RQ11
      PS_LIGHT: ind_d = '{out: 1'b0, oe: 1'b1}; // RQ11
      default: ind_d = '{out: 1'b0, oe: 1'b0};
    endcase
  end

  // indicator register, so the pin never glitches on a state change
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      indicatorOut <= 1'b0;
      indicatorOe <= 1'b0;
    end
    else if (clkEn)
    begin
      indicatorOut <= ind_d.out;
      indicatorOe <= ind_d.oe;
    end
  end

  // loop drive stays high in every powered state; the input should echo it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tamper_loop_out <= 1'b0;
    end
    else if (clkEn)
    begin
      tamper_loop_out <= (state_d != PS_OFF); // RQ5
    end
  end

  // a few cycles of low input filter the loop's settle after power-up;
  // counter runs in all hibernate states too
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tamperCnt_q <= 8'h00;
    end
    else if (clkEn)
    begin
      if (!tamper_loop_out || tamperSync)
      begin
        tamperCnt_q <= 8'h00;
      end
      else if (tamperCnt_q != TAMPER_DEBOUNCE)
      begin
        tamperCnt_q <= tamperCnt_q + 8'h01; // RQ5
      end
    end
  end

  // sticky tamper flag; a new break wins over a clear
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tamperFlag <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!pdSync && pdSync_q)
      begin
        tamperFlag <= 1'b0; // hard reset wipes history
      end
      else if (tamperCnt_q == TAMPER_DEBOUNCE)
      begin
        tamperFlag <= 1'b1; // RQ4
      end
      else if (tamperClear)
      begin
        tamperFlag <= 1'b0;
      end
    end
  end
endmodule

// *** mpsc_chk_properties.sv ***
// assertion checker on the power-state control ports
`timescale 1ns/1ps
module mpsc_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic wake_request_in,
  input wire logic powerDown_n,
  input wire mpsc_pkg::mpsc_sleep_t sleepReq,
  input wire logic regulatorEn,
  input wire logic uartEnable,
  input wire logic indicatorOut,
  input wire logic indicatorOe,
  input wire mpsc_pkg::mpsc_state_t powerState
);
  import mpsc_pkg::*;
  // pins act three edges late: two sync stages, then the state register
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_act; powerState == PS_ACTIVE |-> indicatorOut && indicatorOe; endproperty
  a_act: assert property (p_act) else $error("indicator not high");
  property p_lit; powerState == PS_LIGHT |-> indicatorOe && !indicatorOut; endproperty
  a_lit: assert property (p_lit) else $error("indicator not low");
  property p_hiz; powerState inside {PS_DEEP, PS_DEEPEST} |-> !indicatorOe; endproperty
  a_hiz: assert property (p_hiz) else $error("indicator driven");
  property p_ser; uartEnable |-> powerState == PS_ACTIVE; endproperty
  a_ser: assert property (p_ser) else $error("serial open");
  property p_off; (clkEn && !powerDown_n)[*3] |=> powerState == PS_OFF && !regulatorEn;
  endproperty
  a_off: assert property (p_off) else $error("not off");
  property p_on; (clkEn && powerDown_n && powerState == PS_OFF)[*3] |=> regulatorEn;
  endproperty
  a_on: assert property (p_on) else $error("not on");
  property p_wak; (clkEn && powerDown_n && wake_request_in)[*3] |=> powerState == PS_ACTIVE;
  endproperty
  a_wak: assert property (p_wak) else $error("no wake");
  property p_slp; (clkEn && powerDown_n && !wake_request_in)[*3] ##0
    (powerState == PS_ACTIVE && sleepReq == 3'h5) |=> powerState == PS_DEEP; endproperty
  a_slp: assert property (p_slp) else $error("no sleep");
  c_lit: cover property (powerState == PS_LIGHT);
  c_dst: cover property (powerState == PS_DEEPEST);
  c_off: cover property (!regulatorEn ##1 regulatorEn);
endmodule
bind mpsc_power_ctrl mpsc_chk mpsc_chk_i (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .clkEn(clkEn),
  .wake_request_in(wake_request_in),
  .powerDown_n(powerDown_n),
  .sleepReq(sleepReq),
  .regulatorEn(regulatorEn),
  .uartEnable(uartEnable),
  .indicatorOut(indicatorOut),
  .indicatorOe(indicatorOe),
  .powerState(powerState)
);

// *** mpsc_host.sv ***
// host pin model: wake, power-down and tamper loop return
`timescale 1ns/1ps
module mpsc_host (
  input wire logic tamper_loop_out,
  input wire logic cutLoop,
  output logic wake_request_in,
  output logic powerDown_n,
  output logic tamper_loop_in
);
  // a cut loop reads ground, like an unused input
  // loop return is the module's own drive; host back-feeds no dead io rail
  assign tamper_loop_in = tamper_loop_out & ~cutLoop;
  // defined levels from time zero, never floating
  initial
  begin
    wake_request_in = 1'b0;
    powerDown_n = 1'b1;
  end
endmodule

// *** test_module_power_state_control.sv ***
// bench for the power-state control block
`timescale 1ns/1ps
module test_module_power_state_control;
  import mpsc_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, cutLoop = 1'b0, tamperClear = 1'b0;
  logic wake_request_in, powerDown_n, tamper_loop_in, tamper_loop_out, tamperFlag;
  logic regulatorEn, coreRun, uartEnable, ioSupplyEn, indicatorOut, indicatorOe;
  mpsc_sleep_t sleepReq = '0;
  mpsc_state_t powerState;
  int err_total = 0, samples_checked = 0;
  int cycleCount = 0;
  wire [9:0] obs = {powerState, coreRun, uartEnable, ioSupplyEn, indicatorOut, indicatorOe};
  localparam logic [9:0] SLP[3] = '{10'h085, 10'h100, 10'h200};
  mpsc_power_ctrl mpsc_power_ctrl_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .wake_request_in(wake_request_in),
    .powerDown_n(powerDown_n),
    .tamper_loop_in(tamper_loop_in),
    .sleepReq(sleepReq),
    .tamperClear(tamperClear),
    .tamper_loop_out(tamper_loop_out),
    .tamperFlag(tamperFlag),
    .regulatorEn(regulatorEn),
    .coreRun(coreRun),
    .uartEnable(uartEnable),
    .ioSupplyEn(ioSupplyEn),
    .indicatorOut(indicatorOut),
    .indicatorOe(indicatorOe),
    .powerState(powerState)
  );
  mpsc_host mpsc_host_i (
    .tamper_loop_out(tamper_loop_out),
    .cutLoop(cutLoop),
    .wake_request_in(wake_request_in),
    .powerDown_n(powerDown_n),
    .tamper_loop_in(tamper_loop_in)
  );
  // 8 ns clock
  always #4 sys_clk = ~sys_clk;
  task chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task finish_test;
    $display("err_total %0d samples_checked %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task t_power;
    cyc(3);
    chk({regulatorEn, obs[8:0]}, 10'h25f);
  endtask
  // every hibernate depth, each left by the wake pin
  task t_sleep;
    for (int d = 0; d < 3; d++)
    begin
      sleepReq = {1'b1, 2'(d)};
      cyc(1);
      sleepReq = '0;
      chk(obs, SLP[d]);
      mpsc_host_i.wake_request_in = 1'b1;
      cyc(3);
      chk(obs, 10'h05f);
      mpsc_host_i.wake_request_in = 1'b0;
      cyc(3);
    end
  endtask
  // clock enable low freezes state and synchronisers alike
  task t_freeze;
    sleepReq = 3'h4;
    cyc(1);
    sleepReq = '0;
    clkEn = 1'b0;
    mpsc_host_i.wake_request_in = 1'b1;
    cyc(4);
    chk(obs, SLP[0]);
    clkEn = 1'b1;
    cyc(3);
    chk(obs, 10'h05f);
    mpsc_host_i.wake_request_in = 1'b0;
    cyc(3);
  endtask
  // loop cut while deepest asleep; a clear during the break loses
  task t_tamper;
    sleepReq = 3'h6;
    cyc(1);
    sleepReq = '0;
    cutLoop = 1'b1;
    cyc(8);
    chk(tamperFlag, 10'h001);
    tamperClear = 1'b1;
    cyc(1);
    chk(tamperFlag, 10'h001);
    tamperClear = 1'b0;
    cutLoop = 1'b0;
    cyc(3);
    tamperClear = 1'b1;
    cyc(1);
    tamperClear = 1'b0;
    chk({tamper_loop_out, tamperFlag, powerState}, 10'h050);
  endtask
  // hard power-down out of hibernate, hold scaled down to five cycles
  task t_pdown;
    mpsc_host_i.powerDown_n = 1'b0;
    cyc(5);
    mpsc_host_i.powerDown_n = 1'b1;
    chk({regulatorEn, obs[8:0]}, 10'h020);
    chk(tamper_loop_out, 10'h000);
    cyc(3);
    chk({regulatorEn, obs[8:0]}, 10'h25f);
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_power;
    t_sleep;
    t_freeze;
    t_tamper;
    t_pdown;
    finish_test;
  end
  // hang guard, about six times the run's length
  initial
  begin
    while (cycleCount < 400)
    begin
      @(posedge sys_clk);
      cycleCount++;
    end
    err_total++;
    finish_test;
  end
endmodule
